// ---- hdl/adc_seq_pkg.sv ----
package adc_seq_pkg;
   localparam int NUM_CH = 8;
   localparam int MAX_SEQ = 4;
   localparam int RES_W = 10;
   // byte offsets on the register bus
   localparam logic [7:0] OFF_CTL2 = 8'h00;
   localparam logic [7:0] OFF_CTL3 = 8'h04;
   localparam logic [7:0] OFF_CTL4 = 8'h08;
   localparam logic [7:0] OFF_CTL5 = 8'h0c;
   localparam logic [7:0] OFF_STAT0 = 8'h10;
   localparam logic [7:0] OFF_PADEN = 8'h14;
   localparam logic [7:0] OFF_PORT = 8'h18;
   localparam logic [7:0] OFF_RES0 = 8'h20;
   localparam logic [7:0] OFF_RES3 = 8'h2c;
   // control_reg_two fields
   localparam int POS_PU = 0;
   localparam int POS_IE = 1;
   localparam int POS_WAI = 2;
   localparam int POS_ETE = 3;
   // control_reg_three / four / five fields
   localparam int POS_S4C = 0;
   localparam int POS_PR = 0;
   localparam int POS_SMP = 5;
   localparam int POS_EIGHT_BIT_RESOLUTION_SEL = 7;
   localparam int POS_CH = 0;
   localparam int POS_MULTI_CHANNEL_BIT = 4;
   // status_reg_zero fields
   localparam int POS_SCF = 0;
   localparam int POS_OVR = 1;
   localparam int POS_BUSY = 2;
   localparam int POS_CUR = 4;
   localparam int POS_CCF = 8;
   // reset values
   localparam logic [4:0] RST_PR = 5'h05;
   localparam logic [7:0] RST_PADEN = 8'h00;
   // conversion timing in converter clocks
   localparam logic [4:0] SAMPLE_BASE = 5'h02;
   localparam logic [4:0] BITS_8 = 5'h08;
   localparam logic [4:0] BITS_10 = 5'h0a;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SAMPLE = 3'b010,
      ST_CONVERT = 3'b100
   } seq_state_t;
endpackage

// ---- hdl/pin_sync.sv ----
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 9
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] level_out
);
   logic [WIDTH-1:0] s1_q, s2_q, s3_q, lvl_q;
   logic [WIDTH-1:0] lvl_d;

   // a bit moves only once stages two and three agree
   always_comb begin
      lvl_d = lvl_q;
      for (int i = 0; i < WIDTH; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            lvl_d[i] = s3_q[i];
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         lvl_q <= '0;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= lvl_d;
      end
   end

   assign level_out = lvl_q;
endmodule

// ---- hdl/adc_control_sequencer.sv ----
`timescale 1ns/1ps
module adc_control_sequencer (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire adc_seq_pkg::apb_req_t apb_req,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] pad_level,
   input wire logic ext_trig,
   input wire logic stop_mode,
   input wire logic wait_mode,
   input wire logic [9:0] adc_data,
   output logic [7:0] pad_buffer_en,
   output logic converter_power_up,
   output logic [2:0] analog_channel,
   output logic analog_sample,
   output logic irq
);
   import adc_seq_pkg::*;

   function automatic logic [4:0] sample_ticks(input logic [1:0] smp);
      sample_ticks = SAMPLE_BASE << smp;
   endfunction

   function automatic logic [4:0] res_ticks(input logic eight_bit_resolution_sel);
      res_ticks = eight_bit_resolution_sel ? BITS_8 : BITS_10;
   endfunction

   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a[1:0] == 2'b00) && (a <= OFF_RES3) &&
                (a != 8'h1c);
   endfunction

   logic [8:0] sync_lvl;
   pin_sync #(.WIDTH(9)) u_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .pin_in({ext_trig, pad_level}),
      .level_out(sync_lvl)
   );

   // register group
   logic pu_q, pu_d, ie_q, ie_d, wai_q, wai_d, ete_q, ete_d;
   logic s4c_q, s4c_d, eight_bit_resolution_sel_q, eight_bit_resolution_sel_d, multi_channel_bit_q, multi_channel_bit_d;
   logic [1:0] smp_q, smp_d;
   logic [4:0] pr_q, pr_d;
   logic [2:0] sch_q, sch_d;
   logic [7:0] paden_q, paden_d;
   logic [31:0] prdata_q, prdata_d, rdata;
   logic pready_q, pready_d, pslverr_q, pslverr_d;
   // sequencer group
   seq_state_t state_q, state_d;
   logic [5:0] presc_q, presc_d;
   logic [4:0] phase_q, phase_d;
   logic [1:0] slot_q, slot_d;
   logic [2:0] chan_q, chan_d;
   logic [RES_W-1:0] res_q [MAX_SEQ];
   logic [RES_W-1:0] res_d [MAX_SEQ];
   logic [MAX_SEQ-1:0] ccf_q, ccf_d;
   logic scf_q, scf_d, ovr_q, ovr_d, trig_prev_q;
   logic sample_q, sample_d, irq_q, irq_d;

   logic wr_en, wr_ctl2, wr_ctl5, wr_stat, trig_rise, halt, busy;
   logic start, abort, tick;
   logic [4:0] phase_inc;
   logic [1:0] seq_last;

   assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite &
                  pready_q;
   assign wr_ctl2 = wr_en & (apb_req.paddr == OFF_CTL2);
   assign wr_ctl5 = wr_en & (apb_req.paddr == OFF_CTL5);
   assign wr_stat = wr_en & (apb_req.paddr == OFF_STAT0);
   assign trig_rise = sync_lvl[8] & ~trig_prev_q;
   assign busy = (state_q != ST_IDLE);
   assign halt = stop_mode | (wait_mode & wai_q);
   // software start only without the external trigger
   assign start = pu_q & ((wr_ctl5 & ~ete_q) |
                  (ete_q & trig_rise));
   assign abort = (wr_ctl2 & (~apb_req.pwdata[POS_PU] |
                  ~apb_req.pwdata[POS_IE])) | ~pu_q;
   // half rate: one converter tick every 2*(pr+1) bus clocks
   assign tick = (presc_q == {pr_q, 1'b1});
   assign phase_inc = phase_q + 5'h01;
   assign seq_last = s4c_q ? 2'h3 : 2'h0;

   always_comb begin
      rdata = '0;
      case (apb_req.paddr)
         OFF_CTL2: begin
            rdata[POS_PU] = pu_q;
            rdata[POS_IE] = ie_q;
            rdata[POS_WAI] = wai_q;
            rdata[POS_ETE] = ete_q;
         end
         OFF_CTL3: rdata[POS_S4C] = s4c_q;
         OFF_CTL4: begin
            rdata[POS_PR +: 5] = pr_q;
            rdata[POS_SMP +: 2] = smp_q;
            rdata[POS_EIGHT_BIT_RESOLUTION_SEL] = eight_bit_resolution_sel_q;
         end
         OFF_CTL5: begin
            rdata[POS_CH +: 3] = sch_q;
            rdata[POS_MULTI_CHANNEL_BIT] = multi_channel_bit_q;
         end
         OFF_STAT0: begin
            rdata[POS_SCF] = scf_q;
            rdata[POS_OVR] = ovr_q;
            rdata[POS_BUSY] = busy;
            rdata[POS_CUR +: 3] = chan_q;
            rdata[POS_CCF +: MAX_SEQ] = ccf_q;
         end
         OFF_PADEN: rdata[7:0] = paden_q;
         // buffer off reads zero, pad stays on the analog side
         OFF_PORT: rdata[7:0] = sync_lvl[7:0] & paden_q;
         default: begin
            if (apb_req.paddr >= OFF_RES0 && apb_req.paddr <= OFF_RES3 &&
                apb_req.paddr[1:0] == 2'b00) begin
               rdata[RES_W-1:0] = res_q[apb_req.paddr[3:2]];
            end
         end
      endcase
   end

   always_comb begin
      pu_d = pu_q;
      ie_d = ie_q;
      wai_d = wai_q;
      ete_d = ete_q;
      s4c_d = s4c_q;
      pr_d = pr_q;
      smp_d = smp_q;
      eight_bit_resolution_sel_d = eight_bit_resolution_sel_q;
      sch_d = sch_q;
      multi_channel_bit_d = multi_channel_bit_q;
      paden_d = paden_q;
      prdata_d = prdata_q;
      // one wait state, answer on the second access cycle
      pready_d = apb_req.psel & apb_req.penable & ~pready_q;
      pslverr_d = pready_d & ~addr_ok(apb_req.paddr);
      if (pready_d) begin
         prdata_d = apb_req.pwrite ? 32'h0000_0000 : rdata;
      end
      if (wr_en) begin
         case (apb_req.paddr)
            OFF_CTL2: begin
               pu_d = apb_req.pwdata[POS_PU];
               ie_d = apb_req.pwdata[POS_IE];
               wai_d = apb_req.pwdata[POS_WAI];
               ete_d = apb_req.pwdata[POS_ETE];
            end
            OFF_CTL3: s4c_d = apb_req.pwdata[POS_S4C];
            OFF_CTL4: begin
               pr_d = apb_req.pwdata[POS_PR +: 5];
               smp_d = apb_req.pwdata[POS_SMP +: 2];
               eight_bit_resolution_sel_d = apb_req.pwdata[POS_EIGHT_BIT_RESOLUTION_SEL];
            end
            OFF_CTL5: begin
               sch_d = apb_req.pwdata[POS_CH +: 3];
               multi_channel_bit_d = apb_req.pwdata[POS_MULTI_CHANNEL_BIT];
            end
            OFF_PADEN: paden_d = apb_req.pwdata[7:0];
            default: begin
            end
         endcase
      end
   end

   always_comb begin
      state_d = state_q;
      presc_d = presc_q;
      phase_d = phase_q;
      slot_d = slot_q;
      chan_d = chan_q;
      res_d = res_q;
      ccf_d = ccf_q;
      scf_d = scf_q;
      ovr_d = ovr_q;
      if (wr_stat && apb_req.pwdata[POS_SCF]) begin
         scf_d = 1'b0;
      end
      if (busy && ete_q && trig_rise) begin
         ovr_d = 1'b1;
      end
      case (state_q)
         ST_IDLE: begin
            presc_d = '0;
            phase_d = '0;
            if (start) begin
               state_d = ST_SAMPLE;
               slot_d = '0;
               chan_d = wr_ctl5 ? apb_req.pwdata[POS_CH +: 3] :
                        sch_q;
               ccf_d = '0;
               ovr_d = 1'b0;
            end
         end
         ST_SAMPLE, ST_CONVERT: begin
            presc_d = tick ? 6'h00 : presc_q + 6'h01;
            if (tick) begin
               phase_d = phase_inc;
               // defaults: two-tick sample, ten-bit result
               if (state_q == ST_SAMPLE &&
                   phase_inc == sample_ticks(smp_q)) begin
                  state_d = ST_CONVERT;
                  phase_d = '0;
               end
               if (state_q == ST_CONVERT &&
                   phase_inc == res_ticks(eight_bit_resolution_sel_q)) begin
                  res_d[slot_q] = eight_bit_resolution_sel_q ? {2'b00, adc_data[9:2]} :
                                  adc_data;
                  ccf_d[slot_q] = 1'b1;
                  phase_d = '0;
                  if (slot_q == seq_last) begin
                     state_d = ST_IDLE;
                     scf_d = 1'b1; // set wins over a clear
                  end else begin
                     state_d = ST_SAMPLE;
                     slot_d = slot_q + 2'h1;
                     chan_d = multi_channel_bit_q ? chan_q + 3'h1 : chan_q;
                  end
               end
            end
            // redo the interrupted conversion once released
            if (halt) begin
               state_d = ST_SAMPLE;
               presc_d = '0;
               phase_d = '0;
            end
            if (abort) begin
               state_d = ST_IDLE;
               presc_d = '0;
               phase_d = '0;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
      sample_d = (state_d == ST_SAMPLE) & ~halt;
      // registered from next-state values, so it drops on the same edge as flag or enable
      irq_d = scf_d & ie_d;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pu_q <= 1'b0;
         ie_q <= 1'b0;
         wai_q <= 1'b0;
         ete_q <= 1'b0;
         s4c_q <= 1'b0;
         pr_q <= RST_PR;
         smp_q <= 2'b00;
         eight_bit_resolution_sel_q <= 1'b0;
         sch_q <= 3'h0;
         multi_channel_bit_q <= 1'b0;
         paden_q <= RST_PADEN;
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pu_q <= pu_d;
         ie_q <= ie_d;
         wai_q <= wai_d;
         ete_q <= ete_d;
         s4c_q <= s4c_d;
         pr_q <= pr_d;
         smp_q <= smp_d;
         eight_bit_resolution_sel_q <= eight_bit_resolution_sel_d;
         sch_q <= sch_d;
         multi_channel_bit_q <= multi_channel_bit_d;
         paden_q <= paden_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         presc_q <= 6'h00;
         phase_q <= 5'h00;
         slot_q <= 2'h0;
         chan_q <= 3'h0;
         for (int i = 0; i < MAX_SEQ; i++) begin
            res_q[i] <= '0;
         end
         ccf_q <= '0;
         scf_q <= 1'b0;
         ovr_q <= 1'b0;
         trig_prev_q <= 1'b0;
         sample_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         state_q <= state_d;
         presc_q <= presc_d;
         phase_q <= phase_d;
         slot_q <= slot_d;
         chan_q <= chan_d;
         res_q <= res_d;
         ccf_q <= ccf_d;
         scf_q <= scf_d;
         ovr_q <= ovr_d;
         trig_prev_q <= sync_lvl[8];
         sample_q <= sample_d;
         irq_q <= irq_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign pad_buffer_en = paden_q;
   assign converter_power_up = pu_q;
   assign analog_channel = chan_q;
   assign analog_sample = sample_q;
   assign irq = irq_q;
endmodule

// ---- testbench/adc_seq_checker.sv ----
`timescale 1ns/1ps
module adc_seq_checker (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire adc_seq_pkg::apb_req_t apb_req,
   input wire logic pready,
   input wire logic stop_mode,
   input wire logic [7:0] pad_buffer_en,
   input wire logic converter_power_up,
   input wire logic [2:0] analog_channel,
   input wire logic analog_sample,
   input wire logic irq
);
   import adc_seq_pkg::*;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   logic wr;
   logic c2_wr;
   assign wr = pready && apb_req.psel && apb_req.penable && apb_req.pwrite;
   assign c2_wr = wr && apb_req.paddr == OFF_CTL2;
   sequence acc_start;
      $rose(apb_req.psel && apb_req.penable);
   endsequence
   sequence one_wait;
      !pready ##1 pready;
   endsequence
   a_one_wait: assert property (acc_start |-> one_wait)
      else $error("pready not after one wait state");
   a_pu_source: assert property ($rose(converter_power_up) |->
      $past(c2_wr && apb_req.pwdata[POS_PU]))
      else $error("power-up rose without a control write");
   a_pu_clear: assert property (
      c2_wr && !apb_req.pwdata[POS_PU] |=> !converter_power_up)
      else $error("power-up stayed set");
   a_pad_copy: assert property (wr && apb_req.paddr == OFF_PADEN
      |=> pad_buffer_en == $past(apb_req.pwdata[7:0]))
      else $error("pad buffer enable not updated");
   a_irq_drop: assert property (
      c2_wr && !apb_req.pwdata[POS_IE] |-> ##2 !irq)
      else $error("irq stayed with enable cleared");
   a_irq_clear: assert property (wr && apb_req.paddr == OFF_STAT0
      && apb_req.pwdata[POS_SCF] |-> ##2 !irq)
      else $error("irq stayed after flag clear");
   a_idle_down: assert property (
      !converter_power_up && $past(!converter_power_up) |-> !analog_sample)
      else $error("sampling while powered down");
   a_stop_hold: assert property (
      stop_mode && $past(stop_mode) |-> $stable(analog_channel))
      else $error("channel moved in stop mode");
   a_irq_power: assert property ($rose(irq) |-> converter_power_up)
      else $error("irq while powered down");
endmodule

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
   $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
bind adc_control_sequencer adc_seq_checker u_adc_seq_checker (
   .core_clk(core_clk), .rst_n(rst_n), .apb_req(apb_req), .pready(pready),
   .stop_mode(stop_mode), .pad_buffer_en(pad_buffer_en),
   .converter_power_up(converter_power_up), .analog_channel(analog_channel),
   .analog_sample(analog_sample), .irq(irq));
module tb_top;
   import adc_seq_pkg::*;
   typedef struct {logic [31:0] m; logic [31:0] v; logic e;} exp_t;
   logic core_clk, rst_n, pready, pslverr, ext_trig, stop_mode, wait_mode;
   logic converter_power_up, analog_sample, irq, samp_q;
   apb_req_t req;
   logic [31:0] prdata, m;
   logic [7:0] pad_level, pad_buffer_en;
   logic [9:0] adc_data, r;
   logic [2:0] analog_channel, c;
   int miscompares, n_compared;
   exp_t exp_q[$];
   logic [2:0] ch_q[$];
   exp_t x;
   adc_control_sequencer u_adc_control_sequencer (
      .core_clk(core_clk), .rst_n(rst_n), .apb_req(req), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pad_level(pad_level),
      .ext_trig(ext_trig), .stop_mode(stop_mode), .wait_mode(wait_mode),
      .adc_data(adc_data), .pad_buffer_en(pad_buffer_en),
      .converter_power_up(converter_power_up),
      .analog_channel(analog_channel), .analog_sample(analog_sample),
      .irq(irq));
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic close_out;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // m masks read data; writes expect zero data and the given error
   task automatic xfer(input logic w, input logic [7:0] a,
         input logic [31:0] d, input logic [31:0] mk, input logic [31:0] v,
         input logic e);
      int k;
      exp_q.push_back('{mk, v, e});
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge core_clk);
      req.penable <= 1'b1;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         miscompares++;
         close_out;
      end
      req <= '0;
      @(posedge core_clk);
   endtask
   task automatic wait_irq;
      int k;
      k = 0;
      while (irq !== 1'b1 && k < 3000) begin
         @(posedge core_clk);
         k++;
      end
      `CHK(irq, 1'b1)
      if (irq !== 1'b1) begin
         close_out;
      end
   endtask
   // power-up first, recovery wait, control five last since it starts
   task automatic run(input logic [31:0] c2, c3, c4, c5);
      xfer(1, OFF_CTL2, c2, 0, 0, 0);
      cycles(10);
      xfer(1, OFF_CTL3, c3, 0, 0, 0);
      xfer(1, OFF_CTL4, c4, 0, 0, 0);
      xfer(1, OFF_CTL5, c5, 0, 0, 0);
   endtask
   // reply checker: sampled values at the edge, before updates land
   always @(posedge core_clk) begin
      samp_q <= analog_sample;
      if (analog_sample === 1'b1 && samp_q === 1'b0) begin
         ch_q.push_back(analog_channel);
      end
      if (pready === 1'b1) begin
         if (exp_q.size() == 0) begin
            miscompares++;
            $display("wrong value at %0t: unexpected reply", $time);
         end else begin
            x = exp_q.pop_front();
            `CHK(prdata & x.m, x.v)
            `CHK(pslverr, x.e)
         end
      end
   end
   initial begin
      rst_n = 1'b0;
      req = '0;
      pad_level = '0;
      ext_trig = 1'b0;
      stop_mode = 1'b0;
      wait_mode = 1'b0;
      adc_data = '0;
      samp_q = 1'b0;
      void'($urandom(32'h2dfb33be));
      cycles(20);
      rst_n <= 1'b1;
      cycles(1);
      xfer(0, OFF_CTL2, 0, 32'hf, 0, 0);
      xfer(0, OFF_CTL4, 0, 32'hff, {27'h0, RST_PR}, 0);
      xfer(1, 8'h1c, $urandom, 0, 0, 1);
      xfer(0, 8'h1c, 0, '1, 0, 1);
      m = $urandom;
      r = 10'($urandom);
      pad_level <= 8'($urandom);
      adc_data <= r;
      xfer(1, OFF_PADEN, {24'h0, m[7:0]}, 0, 0, 0);
      cycles(5);
      xfer(0, OFF_PADEN, 0, '1, {24'h0, m[7:0]}, 0);
      xfer(0, OFF_PORT, 0, '1, {24'h0, m[7:0] & pad_level}, 0);
      xfer(1, OFF_CTL5, 32'h10, 0, 0, 0);
      cycles(50);
      xfer(0, OFF_STAT0, 0, 32'h5, 0, 0);
      `CHK(ch_q.size() == 0, 1'b1)
      run(3, 1, 0, 32'h10);
      wait_irq;
      `CHK(ch_q.size() == 4, 1'b1)
      for (int i = 0; i < 4; i++) begin
         c = ch_q.pop_front();
         `CHK(c, i[2:0])
      end
      xfer(0, OFF_RES3, 0, '1, {22'h0, r}, 0);
      xfer(0, OFF_STAT0, 0, 32'h1, 32'h1, 0);
      xfer(1, OFF_STAT0, 1, 0, 0, 0);
      `CHK(irq, 1'b0)
      xfer(0, OFF_STAT0, 0, 32'h1, 0, 0);
      // stop, then wait with the halt bit; 30 clocks outlasts a conversion
      for (int i = 0; i < 2; i++) begin
         run(i ? 32'h7 : 32'h3, 0, 32'h80, 32'h5);
         cycles(5);
         stop_mode <= !i;
         wait_mode <= i[0];
         c = analog_channel;
         cycles(30);
         `CHK(analog_channel, c)
         `CHK(irq, 1'b0)
         stop_mode <= 1'b0;
         wait_mode <= 1'b0;
         wait_irq;
         xfer(0, OFF_RES0, 0, '1, {24'h0, r[9:2]}, 0);
         xfer(1, OFF_STAT0, 1, 0, 0, 0);
      end
      for (int i = 0; i < 2; i++) begin
         run(3, 0, 0, 0);
         cycles(5);
         xfer(1, OFF_CTL2, i ? 32'h0 : 32'h1, 0, 0, 0);
         cycles(60);
         xfer(0, OFF_STAT0, 0, 32'h5, 0, 0);
         // flag first, then enable and power-up cleared in one write
         xfer(1, OFF_STAT0, 1, 0, 0, 0);
         xfer(1, OFF_CTL2, 32'h0, 0, 0, 0);
      end
      run(32'hb, 0, 0, 0);
      cycles(100);
      `CHK(irq, 1'b0)
      for (int i = 0; i < 2; i++) begin
         ext_trig <= 1'b1;
         cycles(3);
         ext_trig <= 1'b0;
         cycles(3);
      end
      wait_irq;
      xfer(0, OFF_STAT0, 0, 32'h2, 32'h2, 0);
      xfer(1, OFF_STAT0, 1, 0, 0, 0);
      run(3, 0, 0, 0);
      cycles(3);
      xfer(0, OFF_STAT0, 0, 32'h2, 0, 0);
      wait_irq;
      close_out;
   end
endmodule
